// [common/spio_pkg.sv]
// Shared constants, carrier types and decode helpers for the B/C/D port block.
// Assumes a 32-bit AXI4-Lite register bus, one register per aligned word.
package spio_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_B_LATCH = 6'h01;
   localparam logic [5:0] IDX_C_LATCH = 6'h02;
   localparam logic [5:0] IDX_D_LATCH = 6'h03;
   localparam logic [5:0] IDX_B_DIR   = 6'h05;
   localparam logic [5:0] IDX_C_DIR   = 6'h06;
   localparam logic [5:0] IDX_D_DIR   = 6'h07;
   localparam logic [5:0] IDX_CHSEL   = 6'h08;
   // Reset values
   localparam logic [7:0] DIR_RST     = 8'h00;
   localparam logic [4:0] CHSEL_RST   = 5'h1f;
   // Field layout
   localparam int         C_CLKEN_BIT = 7;
   localparam logic [7:0] C_LATCH_MSK = 8'h3f;
   localparam logic [7:0] C_DIR_MSK   = 8'hbf;
   localparam logic [7:0] C_CLK_PIN   = 8'h04;
   localparam logic [7:0] D_CH_MSK    = 8'h7f;
   localparam int         D_TMR1_BIT  = 6;
   localparam int         D_TMR2_BIT  = 4;
   localparam logic [4:0] B_CH_BASE   = 5'h00;
   localparam logic [4:0] D_CH_BASE   = 5'h08;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Pin drive pair for one eight-pin port
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
   } spio_drive_t;

   typedef enum logic [0:0] {WS_COLLECT = 1'b0, WS_RESP = 1'b1} spio_wr_state_t;
   typedef enum logic [0:0] {RS_IDLE = 1'b0, RS_DATA = 1'b1} spio_rd_state_t;

   // One-hot pin mask for the converter channel that falls in an eight-pin port
   function automatic logic [7:0] spio_chan_mask(input logic [4:0] sel, input logic [4:0] base);
      logic [4:0] rel;
      rel = sel - base;
      spio_chan_mask = (sel >= base && rel < 5'h08) ? (8'h01 << rel[2:0]) : 8'h00;
   endfunction : spio_chan_mask
endpackage : spio_pkg

// [design/spio_pin_sync.sv]
// Three-stage input synchroniser with an agreement filter for external pins.
// Assumes pins are asynchronous to aclk; output is a registered, filtered level.
`timescale 1ns/1ns
module spio_pin_sync #(
   parameter int W = 8
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] pin_raw,
   output logic      [W-1:0] pin_lvl
);
   import spio_pkg::*;

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   // Stage one feeds only stage two, to keep metastability contained
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pin_raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // A bit changes only once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_lvl <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               pin_lvl[i] <= s3_r[i];
            end
         end
      end
   end
endmodule : spio_pin_sync

// [design/spio_port.sv]
// One eight-pin port: pin drive registers and the read-back multiplexer.
// Assumes latch and direction come from the register file on the same clock.
`timescale 1ns/1ns
module spio_port (
   input  wire logic  aclk,
   input  wire logic  aresetn,
   input  wire logic  [7:0] latch,
   input  wire logic  [7:0] dir,
   input  wire logic  [7:0] alt_mask,
   input  wire logic  [7:0] zero_mask,
   input  wire logic  [7:0] clk_mask,
   input  wire logic  clk_lvl,
   input  wire logic  [7:0] pin_lvl,
   output spio_pkg::spio_drive_t drv,
   output logic       [7:0] rd_val
);
   import spio_pkg::*;

   // Output pins off while the peripheral owns the pin; clock override wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drv.oe_n <= 8'hff;
         drv.out  <= 8'h00;
      end else begin
         drv.oe_n <= ~((dir & ~alt_mask) | clk_mask);
         drv.out  <= (latch & ~clk_mask) | (clk_mask & {8{clk_lvl}});
      end
   end

   // Direction picks latch or pin; converter pins read zero as inputs
   always_comb begin
      rd_val = (dir & latch) | (~dir & ~zero_mask & pin_lvl);
   end
endmodule : spio_port

// [design/spio_top.sv]
// Register file, AXI4-Lite slave and pin logic for ports B, C and D.
// Assumes the timer selects and all AXI signals are on aclk; pins are asynchronous.
//
// Notes on behaviour
// - Port B has eight software read/write latch bits that reset leaves alone.
// - Direction bit one enables a pin's output driver; zero leaves it high impedance.
// - Reset clears every port B direction bit, so all B pins are inputs.
// - Port B read returns latch where direction is one, pin level where zero.
// - Data writes with byte lane zero load the latch; an input pin's observed level is unchanged.
// - A five-bit channel select decides which port B pin is a converter input.
// - A converter-selected pin reads zero when input, otherwise its latch value.
// - Direction never drives a converter pin, yet still selects latch or zero.
// - Port C has six read/write latch bits that reset leaves alone.
// - Clock-output enable in direction bit seven drives the clock onto C pin two.
// - Reset clears the clock-output enable.
// - Reset clears all port C direction bits, making every C pin an input.
// - Port C read returns latch where direction is one, pin level where zero.
// - Port D has eight read/write latch bits, unreset, steered by its direction bits.
// - Port D pins six to zero are converter channels fourteen to eight, same read rule.
// - Port D direction does not drive pins the timers use.
// - While a timer external clock is selected, its D pin direction bit does not drive the pin, yet still selects latch or pin level on read.
// - Reset clears all eight port D direction bits.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ns
module spio_top (
   input  wire logic   aclk,
   input  wire logic   aresetn,
   input  wire logic   [7:0] awaddr,
   input  wire logic   awvalid,
   output logic        awready,
   input  wire logic   [31:0] wdata,
   input  wire logic   [3:0] wstrb,
   input  wire logic   wvalid,
   output logic        wready,
   output logic        [1:0] bresp,
   output logic        bvalid,
   input  wire logic   bready,
   input  wire logic   [7:0] araddr,
   input  wire logic   arvalid,
   output logic        arready,
   output logic        [31:0] rdata,
   output logic        [1:0] rresp,
   output logic        rvalid,
   input  wire logic   rready,
   input  wire logic   [7:0] pb_pin_in,
   output spio_pkg::spio_drive_t pb_drv,
   input  wire logic   [5:0] pc_pin_in,
   output spio_pkg::spio_drive_t pc_drv,
   input  wire logic   [7:0] pd_pin_in,
   output spio_pkg::spio_drive_t pd_drv,
   input  wire logic   timer_one_external_clock_sel,
   input  wire logic   timer_two_external_clock_sel,
   output logic        timer_one_external_clock,
   output logic        timer_two_external_clock,
   output logic        [4:0] converter_channel_select
);
   import spio_pkg::*;

   logic [7:0]     second_port_latch_r;
   logic [7:0]     third_port_latch_r;
   logic [7:0]     fourth_port_latch_r;
   logic [7:0]     second_port_direction_r;
   logic [7:0]     third_port_direction_r;
   logic [7:0]     fourth_port_direction_r;
   logic           clk_div_r;
   logic [7:0]     awaddr_r;
   logic [31:0]    wdata_r;
   logic [3:0]     wstrb_r;
   spio_wr_state_t wr_state_r;
   spio_rd_state_t rd_state_r;
   logic           aw_fire;
   logic           w_fire;
   logic           b_fire;
   logic           ar_fire;
   logic           r_fire;
   logic           do_wr;
   logic [5:0]     wr_idx;
   logic [5:0]     rd_idx;
   logic [7:0]     an_b;
   logic [7:0]     an_d;
   logic [7:0]     tmr_d;
   logic [7:0]     clk_c;
   logic [21:0]    pin_lvl;
   logic [7:0]     rd_b;
   logic [7:0]     rd_c;
   logic [7:0]     rd_d;
   logic [7:0]     rd_sel;

   // Whether an index names a register of this block
   function automatic logic idx_mapped(input logic [5:0] idx);
      idx_mapped = (idx == IDX_B_LATCH) || (idx == IDX_C_LATCH) || (idx == IDX_D_LATCH) ||
                   (idx == IDX_B_DIR) || (idx == IDX_C_DIR) || (idx == IDX_D_DIR) ||
                   (idx == IDX_CHSEL);
   endfunction : idx_mapped

   // Handshake terms
   assign aw_fire = awvalid & awready;
   assign w_fire  = wvalid & wready;
   assign b_fire  = bvalid & bready;
   assign ar_fire = arvalid & arready;
   assign r_fire  = rvalid & rready;
   assign wr_idx  = awaddr_r[7:2];
   assign rd_idx  = araddr[7:2];
   assign do_wr   = (wr_state_r == WS_COLLECT) & ~awready & ~wready;

   // Peripheral ownership masks
   assign an_b  = spio_chan_mask(converter_channel_select, B_CH_BASE);
   assign an_d  = spio_chan_mask(converter_channel_select, D_CH_BASE) & D_CH_MSK;
   assign tmr_d = {1'b0, timer_one_external_clock_sel, 1'b0, timer_two_external_clock_sel, 4'h0};
   assign clk_c = third_port_direction_r[C_CLKEN_BIT] ? C_CLK_PIN : 8'h00;

   // Address and data channels are taken independently, held until the response is gone
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready  <= 1'b1;
         awaddr_r <= 8'h00;
      end else if (aw_fire) begin
         awready  <= 1'b0;
         awaddr_r <= awaddr;
      end else if (b_fire) begin
         awready  <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready  <= 1'b1;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else if (w_fire) begin
         wready  <= 1'b0;
         wdata_r <= wdata;
         wstrb_r <= wstrb;
      end else if (b_fire) begin
         wready  <= 1'b1;
      end
   end

   // Write response one cycle after both halves are held; unmapped gets SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_r <= WS_COLLECT;
         bvalid     <= 1'b0;
         bresp      <= RESP_OKAY;
      end else begin
         unique case (wr_state_r)
            WS_COLLECT: begin
               if (do_wr) begin
                  wr_state_r <= WS_RESP;
                  bvalid     <= 1'b1;
                  bresp      <= idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
               end
            end
            WS_RESP: begin
               if (b_fire) begin
                  wr_state_r <= WS_COLLECT;
                  bvalid     <= 1'b0;
               end
            end
         endcase
      end
   end

   // Data latches carry no reset: their content survives a system reset
   always_ff @(posedge aclk) begin
      if (do_wr && wstrb_r[0]) begin
         if (wr_idx == IDX_B_LATCH) second_port_latch_r <= wdata_r[7:0];
         if (wr_idx == IDX_C_LATCH) third_port_latch_r  <= wdata_r[7:0] & C_LATCH_MSK;
         if (wr_idx == IDX_D_LATCH) fourth_port_latch_r <= wdata_r[7:0];
      end
   end

   // Direction, clock-output enable and channel select
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         second_port_direction_r  <= DIR_RST;
         third_port_direction_r   <= DIR_RST;
         fourth_port_direction_r  <= DIR_RST;
         converter_channel_select <= CHSEL_RST;
      end else if (do_wr && wstrb_r[0]) begin
         if (wr_idx == IDX_B_DIR) second_port_direction_r <= wdata_r[7:0];
         if (wr_idx == IDX_C_DIR) third_port_direction_r  <= wdata_r[7:0] & C_DIR_MSK;
         if (wr_idx == IDX_D_DIR) fourth_port_direction_r <= wdata_r[7:0];
         if (wr_idx == IDX_CHSEL) converter_channel_select <= wdata_r[4:0];
      end
   end

   // Clock output is the system clock divided by two, so it can leave from a flop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_div_r <= 1'b0;
      end else begin
         clk_div_r <= ~clk_div_r;
      end
   end

   // Pins are sampled through the three-stage filter before any read or timer use
   spio_pin_sync #(.W(22)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_raw ({pd_pin_in, pc_pin_in, pb_pin_in}),
      .pin_lvl (pin_lvl)
   );

   spio_port u_port_b (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .latch     (second_port_latch_r),
      .dir       (second_port_direction_r),
      .alt_mask  (an_b),
      .zero_mask (an_b),
      .clk_mask  (8'h00),
      .clk_lvl   (1'b0),
      .pin_lvl   (pin_lvl[7:0]),
      .drv       (pb_drv),
      .rd_val    (rd_b)
   );

   // Upper two port C pins do not exist; their direction bits are masked off
   spio_port u_port_c (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .latch     (third_port_latch_r),
      .dir       (third_port_direction_r & C_LATCH_MSK),
      .alt_mask  (8'h00),
      .zero_mask (8'h00),
      .clk_mask  (clk_c),
      .clk_lvl   (clk_div_r),
      .pin_lvl   ({2'b00, pin_lvl[13:8]}),
      .drv       (pc_drv),
      .rd_val    (rd_c)
   );

   spio_port u_port_d (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .latch     (fourth_port_latch_r),
      .dir       (fourth_port_direction_r),
      .alt_mask  (an_d | tmr_d),
      .zero_mask (an_d),
      .clk_mask  (8'h00),
      .clk_lvl   (1'b0),
      .pin_lvl   (pin_lvl[21:14]),
      .drv       (pd_drv),
      .rd_val    (rd_d)
   );

   // Timer clocks come from the filtered pin flops
   assign timer_one_external_clock = pin_lvl[14 + D_TMR1_BIT];
   assign timer_two_external_clock = pin_lvl[14 + D_TMR2_BIT];

   // Read multiplexer; unmapped words read zero
   always_comb begin
      unique case (rd_idx)
         IDX_B_LATCH: rd_sel = rd_b;
         IDX_C_LATCH: rd_sel = rd_c & C_LATCH_MSK;
         IDX_D_LATCH: rd_sel = rd_d;
         IDX_B_DIR:   rd_sel = second_port_direction_r;
         IDX_C_DIR:   rd_sel = third_port_direction_r;
         IDX_D_DIR:   rd_sel = fourth_port_direction_r;
         IDX_CHSEL:   rd_sel = {3'h0, converter_channel_select};
         default:     rd_sel = 8'h00;
      endcase
   end

   // Read answer one cycle after the address is taken, held until rready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_r <= RS_IDLE;
         arready    <= 1'b1;
         rvalid     <= 1'b0;
         rdata      <= 32'h0000_0000;
         rresp      <= RESP_OKAY;
      end else begin
         unique case (rd_state_r)
            RS_IDLE: begin
               if (ar_fire) begin
                  rd_state_r <= RS_DATA;
                  arready    <= 1'b0;
                  rvalid     <= 1'b1;
                  rdata      <= {24'h00_0000, rd_sel};
                  rresp      <= idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
               end
            end
            RS_DATA: begin
               if (r_fire) begin
                  rd_state_r <= RS_IDLE;
                  arready    <= 1'b1;
                  rvalid     <= 1'b0;
               end
            end
         endcase
      end
   end

   // Checks
   property p_rst_dir;
      @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> (second_port_direction_r == 8'h00) && (third_port_direction_r == 8'h00) &&
                         (fourth_port_direction_r == 8'h00);
   endproperty
   a_rst_dir: assert property (p_rst_dir) else $error("direction not cleared by reset");

   property p_oe_b;
      @(posedge aclk) disable iff (!aresetn)
      ##1 pb_drv.oe_n == ~($past(second_port_direction_r) & ~$past(an_b));
   endproperty
   a_oe_b: assert property (p_oe_b) else $error("port B driver enable wrong");

   property p_rd_b;
      @(posedge aclk) disable iff (!aresetn)
      ar_fire && (rd_idx == IDX_B_LATCH) |=> rvalid && (rdata == {24'h00_0000, $past(rd_b)});
   endproperty
   a_rd_b: assert property (p_rd_b) else $error("port B read data wrong");

   property p_wr_b;
      @(posedge aclk) disable iff (!aresetn)
      do_wr && wstrb_r[0] && (wr_idx == IDX_B_LATCH) |=> second_port_latch_r == $past(wdata_r[7:0]);
   endproperty
   a_wr_b: assert property (p_wr_b) else $error("port B latch not written");

   // Latch is unknown until its first write, so the hold check waits for one
   logic b_latch_known_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) b_latch_known_r <= 1'b0;
      else if (do_wr && wstrb_r[0] && (wr_idx == IDX_B_LATCH)) b_latch_known_r <= 1'b1;
   end

   property p_hold_b;
      @(posedge aclk) disable iff (!aresetn)
      b_latch_known_r && !(do_wr && (wr_idx == IDX_B_LATCH)) |=> $stable(second_port_latch_r);
   endproperty
   a_hold_b: assert property (p_hold_b) else $error("port B latch changed without write");

   property p_an_zero;
      @(posedge aclk) disable iff (!aresetn)
      ((rd_b & an_b & ~second_port_direction_r) == 8'h00) && ((rd_d & an_d & ~fourth_port_direction_r) == 8'h00);
   endproperty
   a_an_zero: assert property (p_an_zero) else $error("converter input not read as zero");

   property p_clk_out;
      @(posedge aclk) disable iff (!aresetn)
      third_port_direction_r[C_CLKEN_BIT] && $past(third_port_direction_r[C_CLKEN_BIT])
         |=> !pc_drv.oe_n[2] && (pc_drv.out[2] != $past(pc_drv.out[2]));
   endproperty
   a_clk_out: assert property (p_clk_out) else $error("clock not driven on port C pin 2");

   property p_c_upper;
      @(posedge aclk) disable iff (!aresetn)
      ar_fire && (rd_idx == IDX_C_LATCH) |=> rdata[7:6] == 2'b00;
   endproperty
   a_c_upper: assert property (p_c_upper) else $error("port C upper bits not zero");

   property p_tmr;
      @(posedge aclk) disable iff (!aresetn)
      timer_one_external_clock_sel |=> pd_drv.oe_n[D_TMR1_BIT];
   endproperty
   a_tmr: assert property (p_tmr) else $error("timer clock pin driven");

   property p_bresp;
      @(posedge aclk) disable iff (!aresetn)
      aw_fire && w_fire |=> ##1 bvalid;
   endproperty
   a_bresp: assert property (p_bresp) else $error("write response late");
endmodule : spio_top

// [sim/spio_pin_model.sv]
// Pin model for one eight-pin port: resolves the pad level seen from outside.
// Assumes the outside world holds each pin at a level the bench chooses.
`timescale 1ns/1ns
module spio_pin_model
   import spio_pkg::*;
(
   input  wire spio_drive_t drv,
   input  wire logic [7:0]  ext,
   output logic      [7:0]  pin
);
   // Driver wins where its enable is low; the bench level shows elsewhere
   always_comb pin = (drv.out & ~drv.oe_n) | (ext & drv.oe_n);
endmodule : spio_pin_model

// [sim/spio_top_test.sv]
// Self-checking bench for the port B/C/D block over AXI4-Lite.
// Assumes pin levels settle in the pin model; pin reads wait out the input filter.
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module spio_top_test;
   import spio_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr, pb_ext, pc_ext, pd_ext, pb_pin, pc_pin, pd_pin;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   logic t1_sel, t2_sel, t1_clk, t2_clk, c2_prev;
   logic [4:0] chsel;
   logic [31:0] rd;
   spio_drive_t pb_drv, pc_drv, pd_drv;
   int fail_count, checked, cyc;

   spio_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .pb_pin_in(pb_pin), .pb_drv(pb_drv), .pc_pin_in(pc_pin[5:0]),
      .pc_drv(pc_drv), .pd_pin_in(pd_pin), .pd_drv(pd_drv), .timer_one_external_clock_sel(t1_sel),
      .timer_two_external_clock_sel(t2_sel), .timer_one_external_clock(t1_clk),
      .timer_two_external_clock(t2_clk), .converter_channel_select(chsel));
   spio_pin_model i_pb (.drv(pb_drv), .ext(pb_ext), .pin(pb_pin));
   spio_pin_model i_pc (.drv(pc_drv), .ext(pc_ext), .pin(pc_pin));
   spio_pin_model i_pd (.drv(pd_drv), .ext(pd_ext), .pin(pd_pin));

   // Clock at 25 MHz
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // Hang guard: a few thousand cycles is far beyond the expected run
   initial begin
      cyc = 0;
      forever begin
         @(posedge aclk);
         cyc++;
         if (cyc > 5000) begin
            fail_count++;
            end_of_test();
         end
      end
   end

   task automatic end_of_test();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask : wt

   // Write one register; address and data offered together, each dropped once taken
   task automatic axw(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axr

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      axw(idx, d, resp);
      `CHK(resp, RESP_OKAY)
   endtask : wr

   task automatic rd_chk(input logic [5:0] idx, input logic [7:0] e);
      axr(idx, rd, resp);
      `CHK(rd, {24'h000000, e})
   endtask : rd_chk

   // Reset state: all pins released, directions and clock enable clear
   task automatic t_reset_values();
      `CHK(pb_drv.oe_n, 8'hff)
      `CHK(pc_drv.oe_n, 8'hff)
      `CHK(pd_drv.oe_n, 8'hff)
      rd_chk(IDX_B_DIR, 8'h00);
      rd_chk(IDX_C_DIR, 8'h00);
      rd_chk(IDX_D_DIR, 8'h00);
      `CHK(chsel, CHSEL_RST)
   endtask : t_reset_values

   // Mixed directions on port B: latch on outputs, pin level on inputs
   task automatic t_port_b_mixed();
      pb_ext <= 8'h3c;
      wr(IDX_B_LATCH, 8'ha5);
      wr(IDX_B_DIR, 8'hf0);
      wt(8);
      `CHK(pb_drv.oe_n, 8'h0f)
      `CHK(pb_drv.out & 8'hf0, 8'ha0)
      rd_chk(IDX_B_LATCH, 8'hac);
      wr(IDX_B_LATCH, 8'h5a);
      wt(8);
      rd_chk(IDX_B_LATCH, 8'h5c);
   endtask : t_port_b_mixed

   // Mid-run reset clears direction but keeps the latch
   task automatic t_second_reset();
      @(posedge aclk);
      aresetn <= 1'b0;
      wt(2);
      aresetn <= 1'b1;
      wt(1);
      `CHK(pb_drv.oe_n, 8'hff)
      rd_chk(IDX_B_DIR, 8'h00);
      wr(IDX_B_DIR, 8'hff);
      rd_chk(IDX_B_LATCH, 8'h5a);
   endtask : t_second_reset

   // Converter channel three on port B: released pin, zero when input
   task automatic t_port_b_conv();
      pb_ext <= 8'hff;
      wr(IDX_CHSEL, {3'h0, B_CH_BASE + 5'h03});
      wt(3);
      `CHK(pb_drv.oe_n, 8'h08)
      rd_chk(IDX_B_LATCH, 8'h5a);
      wr(IDX_B_DIR, 8'h00);
      wt(8);
      rd_chk(IDX_B_LATCH, 8'hf7);
   endtask : t_port_b_conv

   // Port C: six latch bits, upper bits zero, clock output on pin two
   task automatic t_port_c();
      pc_ext <= 8'h15;
      wr(IDX_C_LATCH, 8'hff);
      wt(8);
      rd_chk(IDX_C_LATCH, 8'h15);
      wr(IDX_C_DIR, 8'h3f);
      rd_chk(IDX_C_LATCH, 8'h3f);
      wr(IDX_C_DIR, 8'hc0);
      rd_chk(IDX_C_DIR, 8'h80);
      wt(2);
      `CHK(pc_drv.oe_n, 8'hfb)
      c2_prev = pc_drv.out[2];
      wt(1);
      `CHK(pc_drv.out[2], ~c2_prev)
      wr(IDX_C_DIR, 8'h00);
      wt(2);
      `CHK(pc_drv.oe_n, 8'hff)
   endtask : t_port_c

   // Port D: both timers on pins six and four, then converter channel fourteen on pin six
   task automatic t_port_d();
      pd_ext <= 8'hff;
      wr(IDX_D_LATCH, 8'h5a);
      wr(IDX_D_DIR, 8'hff);
      wt(2);
      `CHK(pd_drv.oe_n, 8'h00)
      `CHK(pd_drv.out, 8'h5a)
      t1_sel <= 1'b1;
      t2_sel <= 1'b1;
      wt(3);
      `CHK(pd_drv.oe_n, 8'h50)
      `CHK(t1_clk, 1'b1)
      t1_sel <= 1'b0;
      wr(IDX_CHSEL, {3'h0, D_CH_BASE + 5'h06});
      wt(3);
      `CHK(pd_drv.oe_n, 8'h50)
      rd_chk(IDX_D_LATCH, 8'h5a);
      wr(IDX_D_DIR, 8'h00);
      wt(8);
      rd_chk(IDX_D_LATCH, 8'hbf);
      `CHK(t2_clk, 1'b1)
      pd_ext <= 8'haf;
      wt(8);
      `CHK(t2_clk, 1'b0)
      `CHK(t1_clk, 1'b0)
   endtask : t_port_d

   // Unmapped word: error response, nothing returned; a write without byte lane zero changes nothing
   task automatic t_unmapped();
      wstrb <= 4'he;
      wr(IDX_D_DIR, 8'h55);
      wstrb <= 4'hf;
      rd_chk(IDX_D_DIR, 8'h00);
      axw(6'h0f, 8'h55, resp);
      `CHK(resp, RESP_SLVERR)
      axr(6'h0f, rd, resp);
      `CHK(resp, RESP_SLVERR)
      `CHK(rd, 32'h00000000)
   endtask : t_unmapped

   initial begin
      fail_count = 0;
      checked = 0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, t1_sel, t2_sel} = 7'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h00000000;
      wstrb = 4'hf;
      {pb_ext, pc_ext, pd_ext} = 24'h000000;
      wt(2);
      aresetn <= 1'b1;
      wt(1);
      t_reset_values();
      t_port_b_mixed();
      t_second_reset();
      t_port_b_conv();
      t_port_c();
      t_port_d();
      t_unmapped();
      end_of_test();
   end
endmodule : spio_top_test
